// ==== vts_pkg.sv ====
// package: constants and types for the voltage transformer supervision block
`default_nettype none
package vts_pkg;
  // ---------------------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_THRESH = 8'h04;
  localparam logic [7:0] REG_ANGLE = 8'h08;
  localparam logic [7:0] REG_DELAY = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_REMAIN = 8'h14;
  localparam logic [7:0] REG_PREFAULT = 8'h18;
  localparam logic [7:0] REG_EVENT = 8'h1C;
  localparam logic [7:0] REG_EVTIME = 8'h20;
  // ---------------------------------------------------------------------------
  // control fields and reset values
  // ---------------------------------------------------------------------------
  localparam int CTRL_BUS_CHK = 0;
  localparam int CTRL_LINE_CHK = 1;
  localparam int CTRL_FORCE_EN = 2;
  localparam int CTRL_FORCE_BLK = 3;
  localparam int CTRL_CH_SEL = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0003;
  // per-unit in hundredths: 0.05 low, 0.80 high, step 0.01
  localparam logic [7:0] LOW_PU_RST = 8'h05;
  localparam logic [7:0] HIGH_PU_RST = 8'h50;
  // angle in tenths of a degree: 5.00 deg
  localparam logic [15:0] ANGLE_RST = 16'h0032;
  localparam logic [15:0] DELAY_RST = 16'h0014;
  localparam logic [31:0] RESP_OKAY = 32'h0000_0000;
  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int CYCLE_US = 5000;
  localparam int CYCLE_CLKS = CYCLE_US * CLK_MHZ;
  localparam int ANGLE_LAG_MS = 40;
  localparam int ANGLE_LAG_CYC = ANGLE_LAG_MS * 1000 / CYCLE_US;
  localparam int PREFAULT_MS = 20;
  localparam int PREFAULT_CYC = PREFAULT_MS * 1000 / CYCLE_US;
  localparam int MS_US = 1000;
  localparam int MS_CLKS = MS_US * CLK_MHZ;
  // ---------------------------------------------------------------------------
  // status codes
  // ---------------------------------------------------------------------------
  localparam logic [2:0] BUS_DEAD = 3'h0;
  localparam logic [2:0] BUS_OK = 3'h1;
  localparam logic [2:0] BUS_REV = 3'h2;
  localparam logic [2:0] BUS_UNDEF = 3'h3;
  localparam logic [2:0] BUS_PROBLEM = 3'h4;
  localparam logic [2:0] COND_NORMAL = 3'h0;
  localparam logic [2:0] COND_START = 3'h1;
  localparam logic [2:0] COND_LINE_FAIL = 3'h2;
  localparam logic [2:0] COND_BUS_FAIL = 3'h3;
  localparam logic [2:0] COND_BLOCKED = 3'h4;
  typedef enum logic [1:0] {VTS_IDLE, VTS_COUNT, VTS_ALARM, VTS_BLOCKED} vts_state_t;
endpackage : vts_pkg
`default_nettype wire

// ==== vts_top.sv ====
// top: voltage transformer supervision with AXI4-Lite register access
// Operation
// - low on one or high on two: pick-up
// - low threshold per-unit, 0.01 steps, 0.05
// - high threshold per-unit, 0.01 steps, 0.80
// - no angle shift versus 40 ms ago inhibits
// - bus fuse supervision select, default on
// - line fuse supervision select, default on
// - fuse input picks up same cycle
// - start equals pick-up gated by block
// - bus voltage state code 0..4
// - overall condition code 0..4
// - any pick-up gives problem bus code
// - per-phase threshold to magnitude ratio
// - uses RMS, sequence, angles, 5 ms
// - setting selects input channel set
// - 20 ms pre-fault average held
// - block sampled at cycle start
// - block at pick-up: blocked, no processing
// - block during start: release like drop
// - block event with voltages, fault type
// - software block switch in forcing mode
// - remaining time, 5 ms steps, unsigned
// - definite-time delay start to alarm
// - outputs start, bus/line alarm, blocked
// - output edges logged, 1 ms stamp
`default_nettype none
module vts_top #(
  parameter int VW = 16,
  parameter int CYCLE_CLKS = vts_pkg::CYCLE_CLKS,
  parameter int MS_CLKS = vts_pkg::MS_CLKS
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [VW-1:0] volt_a_i [3],
  input wire logic [VW-1:0] volt_b_i [3],
  input wire logic [15:0] angle_a_i [3],
  input wire logic [15:0] angle_b_i [3],
  input wire logic [VW-1:0] positive_seq_voltage_i,
  input wire logic [VW-1:0] negative_seq_voltage_i,
  input wire logic [VW-1:0] zero_seq_voltage_i,
  input wire logic [VW-1:0] nominal_i,
  input wire logic bus_breaker_trip_input_i,
  input wire logic line_breaker_trip_input_i,
  input wire logic block_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic start_o,
  output logic bus_alarm_o,
  output logic line_alarm_o,
  output logic blocked_o,
  output logic tick_o
);
  // ---------------------------------------------------------------------------
  // settings registers
  // ---------------------------------------------------------------------------
  logic [31:0] ctrl;
  logic [7:0] low_pu;
  logic [7:0] high_pu;
  logic [15:0] angle_lim;
  logic [15:0] delay_set;
  logic [31:0] cycle_cnt;
  logic [31:0] ms_cnt;
  logic [31:0] ms_time;
  logic cyc;
  // ---------------------------------------------------------------------------
  // processing cycle and 1 ms time base
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cycle_cnt <= '0;
      cyc <= 1'b0;
    end
    else if (cycle_cnt == 32'(CYCLE_CLKS - 1))
    begin
      cycle_cnt <= '0;
      cyc <= 1'b1;
    end
    else
    begin
      cycle_cnt <= cycle_cnt + 32'h1;
      cyc <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ms_cnt <= '0;
      ms_time <= '0;
    end
    else if (ms_cnt == 32'(MS_CLKS - 1))
    begin
      ms_cnt <= '0;
      ms_time <= ms_time + 32'h1;
    end
    else
      ms_cnt <= ms_cnt + 32'h1;
  end
  // ---------------------------------------------------------------------------
  // comparators, one per phase
  // ---------------------------------------------------------------------------
  logic [VW-1:0] v [3];
  logic [15:0] ang [3];
  logic [2:0] lo_hit;
  logic [2:0] hi_hit;
  logic [2:0] ang_hit;
  logic [15:0] ang_hist [3][vts_pkg::ANGLE_LAG_CYC];
  logic [VW+7:0] low_lim;
  logic [VW+7:0] high_lim;
  // ratio settings-to-magnitude done as cross-multiplied compares
  assign low_lim = nominal_i * low_pu;
  assign high_lim = nominal_i * high_pu;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_ph
      logic [15:0] diff;
      logic [VW+7:0] v100;
      assign v[g] = ctrl[vts_pkg::CTRL_CH_SEL] ? volt_b_i[g] : volt_a_i[g];
      assign ang[g] = ctrl[vts_pkg::CTRL_CH_SEL] ? angle_b_i[g] : angle_a_i[g];
      assign v100 = (VW+8)'(v[g]) * (VW+8)'(100);
      assign lo_hit[g] = v100 < low_lim;
      assign hi_hit[g] = v100 > high_lim;
      assign diff = (ang[g] >= ang_hist[g][vts_pkg::ANGLE_LAG_CYC-1]) ?
                    ang[g] - ang_hist[g][vts_pkg::ANGLE_LAG_CYC-1] :
                    ang_hist[g][vts_pkg::ANGLE_LAG_CYC-1] - ang[g];
      assign ang_hit[g] = diff < angle_lim;
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
        begin
          for (int k = 0; k < vts_pkg::ANGLE_LAG_CYC; k++)
            ang_hist[g][k] <= '0;
        end
        else if (cyc)
        begin
          ang_hist[g][0] <= ang[g];
          for (int k = 1; k < vts_pkg::ANGLE_LAG_CYC; k++)
            ang_hist[g][k] <= ang_hist[g][k-1];
        end
      end
    end
  endgenerate
  // ---------------------------------------------------------------------------
  // pick-up, block and timing
  // ---------------------------------------------------------------------------
  logic volt_pick;
  logic bus_fuse;
  logic line_fuse;
  logic pick;
  logic blk;
  logic [1:0] hi_count;
  vts_pkg::vts_state_t state;
  logic [15:0] remain;
  logic [2:0] cond;
  logic [2:0] bus_code;
  logic [2:0] fault_type;
  assign hi_count = 2'(hi_hit[0]) + 2'(hi_hit[1]) + 2'(hi_hit[2]);
  // steady angles on all phases suppress only the voltage path, fuse inputs stay direct
  assign volt_pick = ((|lo_hit) || (hi_count >= 2'h2)) && !(&ang_hit);
  assign bus_fuse = ctrl[vts_pkg::CTRL_BUS_CHK] && bus_breaker_trip_input_i;
  assign line_fuse = ctrl[vts_pkg::CTRL_LINE_CHK] && line_breaker_trip_input_i;
  assign pick = volt_pick || bus_fuse || line_fuse;
  assign blk = ctrl[vts_pkg::CTRL_FORCE_EN] ? ctrl[vts_pkg::CTRL_FORCE_BLK] : block_i;
  assign fault_type = {line_fuse, bus_fuse, volt_pick};

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state <= vts_pkg::VTS_IDLE;
      remain <= '0;
      start_o <= 1'b0;
      bus_alarm_o <= 1'b0;
      line_alarm_o <= 1'b0;
      blocked_o <= 1'b0;
    end
    else if (cyc)
    begin
      // block is sampled here, at the head of each cycle
      case (state)
        vts_pkg::VTS_IDLE:
        begin
          if (pick && blk)
          begin
            state <= vts_pkg::VTS_BLOCKED;
            blocked_o <= 1'b1;
          end
          else if (pick)
          begin
            state <= vts_pkg::VTS_COUNT;
            start_o <= 1'b1;
            remain <= delay_set;
          end
        end
        vts_pkg::VTS_COUNT:
        begin
          if (!pick || blk)
          begin
            state <= blk ? vts_pkg::VTS_BLOCKED : vts_pkg::VTS_IDLE;
            blocked_o <= blk;
            start_o <= 1'b0;
            remain <= '0;
          end
          else if (remain <= 16'h1)
          begin
            state <= vts_pkg::VTS_ALARM;
            remain <= '0;
            bus_alarm_o <= volt_pick || bus_fuse;
            line_alarm_o <= line_fuse;
          end
          else
            remain <= remain - 16'h1;
        end
        vts_pkg::VTS_ALARM:
        begin
          if (!pick || blk)
          begin
            state <= blk ? vts_pkg::VTS_BLOCKED : vts_pkg::VTS_IDLE;
            blocked_o <= blk;
            start_o <= 1'b0;
            bus_alarm_o <= 1'b0;
            line_alarm_o <= 1'b0;
          end
        end
        vts_pkg::VTS_BLOCKED:
        begin
          if (!blk)
          begin
            state <= vts_pkg::VTS_IDLE;
            blocked_o <= 1'b0;
          end
        end
        default: state <= vts_pkg::VTS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cond <= vts_pkg::COND_NORMAL;
      bus_code <= vts_pkg::BUS_DEAD;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= cyc;
      if (cyc)
      begin
        if (blocked_o)
          cond <= vts_pkg::COND_BLOCKED;
        else if (line_alarm_o)
          cond <= vts_pkg::COND_LINE_FAIL;
        else if (bus_alarm_o)
          cond <= vts_pkg::COND_BUS_FAIL;
        else if (start_o)
          cond <= vts_pkg::COND_START;
        else
          cond <= vts_pkg::COND_NORMAL;
        if (pick)
          bus_code <= vts_pkg::BUS_PROBLEM;
        else if (&lo_hit)
          bus_code <= vts_pkg::BUS_DEAD;
        else if (negative_seq_voltage_i > positive_seq_voltage_i)
          bus_code <= vts_pkg::BUS_REV;
        else if (zero_seq_voltage_i > positive_seq_voltage_i ||
                 negative_seq_voltage_i == positive_seq_voltage_i)
          bus_code <= vts_pkg::BUS_UNDEF;
        else
          bus_code <= vts_pkg::BUS_OK;
      end
    end
  end
  // ---------------------------------------------------------------------------
  // pre-fault average and event capture
  // ---------------------------------------------------------------------------
  logic [VW-1:0] pf_hist [vts_pkg::PREFAULT_CYC];
  logic [VW+1:0] pf_sum;
  logic [VW-1:0] prefault;
  logic [VW-1:0] ev_volt;
  logic [2:0] ev_type;
  logic [3:0] ev_out;
  logic [31:0] ev_time;
  logic ev_blk;
  logic [3:0] prev_out;
  always_comb
  begin
    pf_sum = '0;
    for (int k = 0; k < vts_pkg::PREFAULT_CYC; k++)
      pf_sum = pf_sum + (VW+2)'(pf_hist[k]);
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      for (int k = 0; k < vts_pkg::PREFAULT_CYC; k++)
        pf_hist[k] <= '0;
      prefault <= '0;
    end
    else if (cyc)
    begin
      pf_hist[0] <= positive_seq_voltage_i;
      for (int k = 1; k < vts_pkg::PREFAULT_CYC; k++)
        pf_hist[k] <= pf_hist[k-1];
      if (state == vts_pkg::VTS_IDLE && pick)
        prefault <= VW'(pf_sum >> 2);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      prev_out <= '0;
      ev_out <= '0;
      ev_time <= '0;
      ev_volt <= '0;
      ev_type <= '0;
      ev_blk <= 1'b0;
    end
    else
    begin
      prev_out <= {blocked_o, line_alarm_o, bus_alarm_o, start_o};
      if (prev_out != {blocked_o, line_alarm_o, bus_alarm_o, start_o})
      begin
        ev_out <= {blocked_o, line_alarm_o, bus_alarm_o, start_o};
        ev_time <= ms_time;
        ev_blk <= blocked_o & ~prev_out[3];
        if (blocked_o & ~prev_out[3])
        begin
          ev_volt <= positive_seq_voltage_i;
          ev_type <= fault_type;
        end
      end
    end
  end
  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic aw_full;
  logic w_full;
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_q <= '0;
      w_q <= '0;
      ws_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl <= vts_pkg::CTRL_RST;
      low_pu <= vts_pkg::LOW_PU_RST;
      high_pu <= vts_pkg::HIGH_PU_RST;
      angle_lim <= vts_pkg::ANGLE_RST;
      delay_set <= vts_pkg::DELAY_RST;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (aw_full && w_full && !s_axi_bvalid)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (aw_q)
          vts_pkg::REG_CTRL: if (ws_q[0]) ctrl[7:0] <= {3'h0, w_q[4:0]};
          vts_pkg::REG_THRESH:
          begin
            if (ws_q[0]) low_pu <= w_q[7:0];
            if (ws_q[1]) high_pu <= w_q[15:8];
          end
          vts_pkg::REG_ANGLE: angle_lim <= w_q[15:0];
          vts_pkg::REG_DELAY: delay_set <= w_q[15:0];
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        vts_pkg::REG_CTRL: s_axi_rdata <= ctrl;
        vts_pkg::REG_THRESH: s_axi_rdata <= {16'h0, high_pu, low_pu};
        vts_pkg::REG_ANGLE: s_axi_rdata <= {16'h0, angle_lim};
        vts_pkg::REG_DELAY: s_axi_rdata <= {16'h0, delay_set};
        vts_pkg::REG_STATUS: s_axi_rdata <= {20'h0, 2'(state), bus_code, cond, ev_blk, ev_type};
        vts_pkg::REG_REMAIN: s_axi_rdata <= {delay_set, remain};
        vts_pkg::REG_PREFAULT: s_axi_rdata <= {(32-VW)'(0), prefault};
        vts_pkg::REG_EVENT: s_axi_rdata <= {12'h0, ev_out, 16'(ev_volt)};
        vts_pkg::REG_EVTIME: s_axi_rdata <= ev_time;
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  assign s_axi_arready = !s_axi_rvalid;
endmodule : vts_top
`default_nettype wire

// ==== vts_checker.sv ====
// checker: port-level assertions for the supervision block
`default_nettype none
module vts_checker #(
  parameter int CYCLE_CLKS = 20
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic block_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic start_o,
  input wire logic bus_alarm_o,
  input wire logic line_alarm_o,
  input wire logic blocked_o,
  input wire logic tick_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  // ---------------------------------------------------------------------------
  // clocks since last tick; the first tick after reset has no reference
  // ---------------------------------------------------------------------------
  int gap;
  logic seen;
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      gap <= 0;
      seen <= 1'b0;
    end
    else if (tick_o)
    begin
      gap <= 0;
      seen <= 1'b1;
    end
    else
      gap <= gap + 1;
  end
  AST_RESET_CLEAR: assert property ($fell(srst_i) |->
    !start_o && !bus_alarm_o && !line_alarm_o && !blocked_o) else $error("outputs set after reset");
  AST_TICK_PERIOD: assert property (tick_o && seen |-> gap == CYCLE_CLKS - 1)
    else $error("evaluation period wrong");
  AST_OUT_ON_TICK: assert property (
    $changed({start_o, bus_alarm_o, line_alarm_o, blocked_o}) |-> ##[0:2] tick_o)
    else $error("output off tick");
  AST_START_UNBLOCKED: assert property ($rose(start_o) |-> !$past(block_i))
    else $error("start rose while blocked");
  AST_BLOCK_DROPS_START: assert property (start_o && block_i |-> ##[0:25] !start_o)
    else $error("start kept under block");
  AST_BLOCKED_NO_START: assert property (blocked_o |-> !start_o)
    else $error("start and blocked together");
  AST_ALARM_AFTER_START: assert property ($rose(bus_alarm_o) || $rose(line_alarm_o)
    |-> $past(start_o)) else $error("alarm without start");
  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule // vts_checker
bind vts_top vts_checker #(.CYCLE_CLKS(CYCLE_CLKS)) vts_checker_i (.clk_i, .srst_i, .block_i,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .start_o, .bus_alarm_o, .line_alarm_o, .blocked_o, .tick_o);
`default_nettype wire

// ==== vts_front.sv ====
// partner: measurement front end and fuse inputs feeding the block
`default_nettype none
module vts_front #(
  parameter int CYCLE_CLKS = 20
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic low_a_i,
  input wire logic low_b_i,
  input wire logic spin_i,
  input wire logic [1:0] seq_i,
  input wire logic bus_fuse_i,
  input wire logic line_fuse_i,
  output logic [15:0] volt_a_o [3],
  output logic [15:0] volt_b_o [3],
  output logic [15:0] angle_a_o [3],
  output logic [15:0] angle_b_o [3],
  output logic [15:0] pos_o,
  output logic [15:0] neg_o,
  output logic [15:0] zero_o,
  output logic bus_trip_o,
  output logic line_trip_o
);
  localparam logic [15:0] MAG_OK = 16'h01F4;
  localparam logic [15:0] MAG_LOW = 16'h000A;
  int div;
  logic [3:0] ph;
  always_ff @(posedge clk_i)
  begin
    if (srst_i || div == CYCLE_CLKS - 1)
      div <= 0;
    else
      div <= div + 1;
  end
  // ---------------------------------------------------------------------------
  // refresh once per frame; spin repeats every 12 frames
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (div == 0)
    begin
      ph <= (srst_i || ph == 4'hB) ? 4'h0 : ph + 4'h1;
      for (int i = 0; i < 3; i++)
      begin
        volt_a_o[i] <= (low_a_i && i == 0) ? MAG_LOW : MAG_OK;
        volt_b_o[i] <= (low_b_i && i == 0) ? MAG_LOW : MAG_OK;
        angle_a_o[i] <= 16'(i) * 16'h04B0 + (spin_i ? 16'(ph) * 16'h0064 : 16'h0000);
      end
      pos_o <= (seq_i == 2'h0) ? MAG_OK : 16'h0010;
      neg_o <= (seq_i == 2'h1) ? MAG_OK : 16'h0000;
      zero_o <= (seq_i == 2'h2) ? MAG_OK : 16'h0000;
    end
  end
  assign angle_b_o = angle_a_o;
  assign bus_trip_o = bus_fuse_i;
  assign line_trip_o = line_fuse_i;
endmodule // vts_front
`default_nettype wire

// ==== test_voltage_transformer_supervision.sv ====
// testbench: register access and supervision scenarios for the block
`default_nettype none
module test_voltage_transformer_supervision;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC = 20;
  localparam int S = 3;
  localparam int BA = 2;
  localparam int LA = 1;
  localparam int BK = 0;
  logic clk_i, srst_i, block_i, low_a, low_b, spin, bfuse, lfuse, bt, lt;
  logic [1:0] seq;
  logic [15:0] va [3], vb [3], aa [3], ab [3];
  logic [15:0] pos, neg, zero, nominal;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic start_o, bus_alarm_o, line_alarm_o, blocked_o, tick_o;
  wire [3:0] outs = {start_o, bus_alarm_o, line_alarm_o, blocked_o};
  int n_errors = 0;
  int checks = 0;
  int t;
  vts_front #(.CYCLE_CLKS(CYC)) vts_front_i (.clk_i, .srst_i, .low_a_i(low_a),
    .low_b_i(low_b), .spin_i(spin), .seq_i(seq), .bus_fuse_i(bfuse), .line_fuse_i(lfuse),
    .volt_a_o(va), .volt_b_o(vb), .angle_a_o(aa), .angle_b_o(ab), .pos_o(pos), .neg_o(neg),
    .zero_o(zero), .bus_trip_o(bt), .line_trip_o(lt));
  vts_top #(.CYCLE_CLKS(CYC), .MS_CLKS(4)) vts_top_i (.clk_i, .srst_i, .volt_a_i(va),
    .volt_b_i(vb), .angle_a_i(aa), .angle_b_i(ab), .positive_seq_voltage_i(pos),
    .negative_seq_voltage_i(neg), .zero_seq_voltage_i(zero), .nominal_i(nominal),
    .bus_breaker_trip_input_i(bt), .line_breaker_trip_input_i(lt), .block_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .start_o, .bus_alarm_o,
    .line_alarm_o, .blocked_o, .tick_o);
  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask
  task automatic rf(input logic [7:0] a, input int lsb, input int w, input logic [31:0] exp,
                    input string nm, input logic [1:0] er = 2'h0);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rresp", s_axi_rresp, er);
    chk(nm, (s_axi_rdata >> lsb) & ((32'h1 << w) - 32'h1), exp);
  endtask
  task automatic ticks(input int k);
    repeat (k)
    begin
      @(posedge clk_i);
      while (tick_o !== 1'b1) @(posedge clk_i);
    end
  endtask
  task automatic wait_out(input int b, output int tn);
    tn = 0;
    while (outs[b] !== 1'b1 && tn < 30)
    begin
      ticks(1);
      tn++;
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    results();
  end
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial
  begin
    {srst_i, block_i, low_a, low_b, spin, bfuse, lfuse, seq} = 9'h100;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    nominal = 16'h03E8;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    rf(vts_pkg::REG_CTRL, 0, 5, 32'h3, "ctrl");
    rf(vts_pkg::REG_THRESH, 0, 16, 32'h5005, "thresh");
    rf(vts_pkg::REG_ANGLE, 0, 16, 32'h32, "angle");
    rf(vts_pkg::REG_DELAY, 0, 16, 32'h14, "delay");
    rf(vts_pkg::REG_STATUS, 4, 3, vts_pkg::COND_NORMAL, "cond");
    rf(8'h40, 0, 32, 32'h0, "unmapped", 2'h2);
    wr(8'h40, 32'h0000_00FF, 2'h2);
    wr(vts_pkg::REG_DELAY, 32'h3);
    $display("test registers done");
    for (int m = 0; m < 3; m++)
    begin
      seq <= 2'(m);
      ticks(3);
      rf(vts_pkg::REG_STATUS, 7, 3, 32'(m + 1), "bus_code");
    end
    seq <= 2'h0;
    $display("test bus codes done");
    low_a <= 1'b1;
    ticks(3);
    chk("start_steady", outs, 32'h0);
    spin <= 1'b1;
    wait_out(S, t);
    chk("start_low", outs, 32'h8);
    // condition code follows the outputs one evaluation later
    ticks(1);
    rf(vts_pkg::REG_STATUS, 4, 3, vts_pkg::COND_START, "cond");
    rf(vts_pkg::REG_STATUS, 7, 3, vts_pkg::BUS_PROBLEM, "bus_code");
    rf(vts_pkg::REG_REMAIN, 16, 16, 32'h3, "expected");
    wait_out(BA, t);
    chk("alarm_ticks", 32'(t >= 2 && t <= 4), 32'h1);
    ticks(1);
    rf(vts_pkg::REG_STATUS, 4, 3, vts_pkg::COND_BUS_FAIL, "cond");
    low_a <= 1'b0;
    spin <= 1'b0;
    ticks(2);
    chk("drop", outs, 32'h0);
    $display("test voltage pick-up done");
    lfuse <= 1'b1;
    wait_out(S, t);
    chk("fuse_ticks", 32'(t <= 1), 32'h1);
    wait_out(LA, t);
    ticks(1);
    rf(vts_pkg::REG_STATUS, 4, 3, vts_pkg::COND_LINE_FAIL, "cond");
    lfuse <= 1'b0;
    ticks(2);
    for (int i = 0; i < 2; i++)
    begin
      wr(vts_pkg::REG_CTRL, 32'h3 ^ (32'h1 << i));
      {lfuse, bfuse} <= 2'(1 << i);
      ticks(3);
      chk("fuse_unchecked", outs, 32'h0);
      {lfuse, bfuse} <= 2'h0;
    end
    wr(vts_pkg::REG_CTRL, 32'h3);
    $display("test fuse inputs done");
    block_i <= 1'b1;
    ticks(2);
    bfuse <= 1'b1;
    wait_out(BK, t);
    chk("blocked", outs, 32'h1);
    ticks(1);
    rf(vts_pkg::REG_STATUS, 4, 3, vts_pkg::COND_BLOCKED, "cond");
    rf(vts_pkg::REG_STATUS, 3, 1, 32'h1, "block_event");
    block_i <= 1'b0;
    bfuse <= 1'b0;
    ticks(2);
    bfuse <= 1'b1;
    wait_out(S, t);
    block_i <= 1'b1;
    ticks(2);
    chk("start_cleared", start_o, 32'h0);
    block_i <= 1'b0;
    bfuse <= 1'b0;
    ticks(2);
    wr(vts_pkg::REG_CTRL, 32'hF);
    lfuse <= 1'b1;
    wait_out(BK, t);
    chk("forced_block", outs, 32'h1);
    lfuse <= 1'b0;
    $display("test blocking done");
    wr(vts_pkg::REG_CTRL, 32'h13);
    low_b <= 1'b1;
    spin <= 1'b1;
    wait_out(S, t);
    chk("chan_b", start_o, 32'h1);
    srst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    chk("reset_outs", outs, 32'h0);
    rf(vts_pkg::REG_STATUS, 4, 3, vts_pkg::COND_NORMAL, "cond");
    $display("test channel and reset done");
    results();
  end
endmodule // test_voltage_transformer_supervision
`default_nettype wire
